// ===== rtl/crc32_byte.sv
// Purpose: one byte step of the reflected Ethernet frame CRC
// Assumes: byte enters least significant bit first
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "ptp_ts_cfg.svh"
module crc32_byte (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end
endmodule : crc32_byte
`default_nettype wire

// ===== rtl/ptp_ts_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the timestamp unit
// Assumes: included by the unit's design files and by the testbench
// Notes: byte addresses on a 32-bit AXI4-Lite register bus
`ifndef PTP_TS_CFG_SVH
`define PTP_TS_CFG_SVH
// ==========================================================
// Register byte addresses
`define ADDR_AUX_CTRL 8'h00
`define ADDR_TX_CTRL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CAP_NS 8'h0C
`define ADDR_CAP_SEC_LO 8'h10
`define ADDR_CAP_SEC_HI 8'h14
// ==========================================================
// Field positions
`define AUX_DIS_SYSTIME_BIT 0
`define TXC_EN_BIT 0
`define TXC_OFF_LSB 16
`define ST_CAP_VALID_BIT 0
`define ST_FULL_DUPLEX_BIT 1
`define ST_ACTIVE_BIT 2
// ==========================================================
// Reset values, counts, CRC constants and bus response codes
`define AUX_DIS_SYSTIME_RST 1'b0
`define TXC_EN_RST 1'b0
`define TXC_OFF_RST 16'h0000
`define TS_BYTES 4'hA
`define CRC_BYTES 2'h3
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ===== rtl/ptp_ts_pkg.sv
// Purpose: types shared by the timestamp unit
// Assumes: nothing
// Notes: constants live in ptp_ts_cfg.svh
package ptp_ts_pkg;
    typedef enum logic {TX_DATA, TX_CRC} tx_state_t;
    typedef logic [79:0] stamp_t;
endpackage : ptp_ts_pkg

// ===== rtl/ptp_ts_unit.sv
// Purpose: transmit/receive packet timestamping with one-step insertion
// Assumes: sys_time and the frame streams are on aclk; full_duplex is a pin
// Notes: tx frames enter without CRC; the unit appends it to every frame
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ptp_ts_cfg.svh"
module ptp_ts_unit
    import ptp_ts_pkg::*;
#(
    parameter int OFF_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [79:0] sys_time,
    input wire logic full_duplex,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_valid,
    input wire logic tx_in_last,
    input wire logic two_step_capture_flag,
    input wire logic one_step_insert_flag,
    output logic tx_in_ready,
    output logic [7:0] tx_out_data,
    output logic tx_out_valid,
    output logic tx_out_last,
    input wire logic tx_out_ready,
    input wire logic rx_in_valid,
    input wire logic rx_in_first,
    input wire logic rx_in_last,
    input wire logic rx_in_event,
    output logic [79:0] rx_post_time,
    output logic rx_post_valid,
    input wire logic rx_post_ready
);
    if (OFF_W < 4 || OFF_W > 16) begin : g_chk
        $error("OFF_W must lie in 4..16");
    end

    // Byte k of the stamp, most significant byte first
    function automatic logic [7:0] ts_byte(input stamp_t ts, input logic [3:0] k);
        stamp_t s;
        s = ts << {k, 3'b000};
        return s[79:72];
    endfunction : ts_byte

    // ==========================================================
    // Registers and link state
    logic dis_systime_ff, tx_en_ff, cap_valid_ff;
    logic [OFF_W-1:0] offset_ff;
    stamp_t cap_ff;
    logic fd_meta_ff, fd_ff;
    logic active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fd_meta_ff <= 1'b0;
            fd_ff <= 1'b0;
        end else begin
            fd_meta_ff <= full_duplex;
            fd_ff <= fd_meta_ff;
        end
    end

    // Speed plays no part here; sampling works at any rate
    assign active = fd_ff && !dis_systime_ff;

    // ==========================================================
    // AXI4-Lite write channel
    logic aw_held_ff, w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_write, wr_ok;

    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_ok = awaddr_ff == `ADDR_AUX_CTRL || awaddr_ff == `ADDR_TX_CTRL
        || awaddr_ff == `ADDR_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dis_systime_ff <= `AUX_DIS_SYSTIME_RST;
            tx_en_ff <= `TXC_EN_RST;
            offset_ff <= OFF_W'(`TXC_OFF_RST);
        end else if (do_write) begin
            if (awaddr_ff == `ADDR_AUX_CTRL && wstrb_ff[0]) begin
                dis_systime_ff <= wdata_ff[`AUX_DIS_SYSTIME_BIT];
            end
            if (awaddr_ff == `ADDR_TX_CTRL) begin
                if (wstrb_ff[0]) begin
                    tx_en_ff <= wdata_ff[`TXC_EN_BIT];
                end
                if (wstrb_ff[2] || wstrb_ff[3]) begin
                    offset_ff <= wdata_ff[`TXC_OFF_LSB +: OFF_W];
                end
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_OKAY;
            s_axi_rdata <= 32'h00000000;
            unique case (s_axi_araddr)
                `ADDR_AUX_CTRL: s_axi_rdata[`AUX_DIS_SYSTIME_BIT] <= dis_systime_ff;
                `ADDR_TX_CTRL: begin
                    s_axi_rdata[`TXC_EN_BIT] <= tx_en_ff;
                    s_axi_rdata[`TXC_OFF_LSB +: OFF_W] <= offset_ff;
                end
                `ADDR_STATUS: begin
                    s_axi_rdata[`ST_CAP_VALID_BIT] <= cap_valid_ff;
                    s_axi_rdata[`ST_FULL_DUPLEX_BIT] <= fd_ff;
                    s_axi_rdata[`ST_ACTIVE_BIT] <= active;
                end
                `ADDR_CAP_NS: s_axi_rdata <= cap_ff[31:0];
                `ADDR_CAP_SEC_LO: s_axi_rdata <= cap_ff[63:32];
                `ADDR_CAP_SEC_HI: s_axi_rdata[15:0] <= cap_ff[79:64];
                default: s_axi_rresp <= `AXI_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Transmit path
    tx_state_t state_ff;
    logic first_ff, one_ff;
    logic [OFF_W-1:0] idx_ff;
    logic [1:0] crc_cnt_ff;
    logic [31:0] crc_ff, crc_src, crc_nxt;
    stamp_t hold_ff, cur_ts;
    logic in_fire, out_fire, cur_one, ins, tx_active;
    logic [OFF_W-1:0] cur_idx, rel;
    logic [7:0] nxt_byte;

    assign tx_active = active && tx_en_ff;
    assign in_fire = tx_in_valid && tx_in_ready;
    assign out_fire = tx_out_valid && tx_out_ready;
    // Stamp taken as the first byte enters the last stage before the PHY
    assign cur_ts = first_ff ? sys_time : hold_ff;
    assign cur_one = first_ff ? (one_step_insert_flag && tx_active) : one_ff;
    assign cur_idx = first_ff ? '0 : idx_ff;
    assign rel = cur_idx - offset_ff;
    assign ins = cur_one && cur_idx >= offset_ff && rel < OFF_W'(`TS_BYTES);
    // Only the stamp bytes change; checksums in the payload stay as sent
    assign nxt_byte = ins ? ts_byte(cur_ts, rel[3:0]) : tx_in_data;
    assign crc_src = first_ff ? `CRC_INIT : crc_ff;

    // CRC runs over the byte after insertion
    crc32_byte u_crc (
        .crc_in(crc_src),
        .data(nxt_byte),
        .crc_out(crc_nxt)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= TX_DATA;
            first_ff <= 1'b1;
            one_ff <= 1'b0;
            idx_ff <= '0;
            hold_ff <= '0;
            crc_ff <= `CRC_INIT;
            crc_cnt_ff <= 2'h0;
            tx_in_ready <= 1'b1;
            tx_out_valid <= 1'b0;
            tx_out_last <= 1'b0;
            tx_out_data <= 8'h00;
        end else begin
            unique case (state_ff)
                TX_DATA: begin
                    if (in_fire) begin
                        tx_out_data <= nxt_byte;
                        tx_out_valid <= 1'b1;
                        tx_out_last <= 1'b0;
                        tx_in_ready <= 1'b0;
                        crc_ff <= crc_nxt;
                        hold_ff <= cur_ts;
                        one_ff <= cur_one;
                        // Index saturates; offsets beyond it never match
                        if (cur_idx != '1) begin
                            idx_ff <= cur_idx + 1'b1;
                        end else begin
                            idx_ff <= cur_idx;
                        end
                        first_ff <= tx_in_last;
                        if (tx_in_last) begin
                            state_ff <= TX_CRC;
                            crc_cnt_ff <= 2'h0;
                        end
                    end else if (out_fire) begin
                        tx_out_valid <= 1'b0;
                        tx_in_ready <= 1'b1;
                    end
                end
                TX_CRC: begin
                    if (out_fire || !tx_out_valid) begin
                        if (out_fire && tx_out_last) begin
                            tx_out_valid <= 1'b0;
                            tx_out_last <= 1'b0;
                            tx_in_ready <= 1'b1;
                            state_ff <= TX_DATA;
                        end else begin
                            tx_out_data <= ~crc_ff[{crc_cnt_ff, 3'b000} +: 8];
                            tx_out_valid <= 1'b1;
                            tx_out_last <= crc_cnt_ff == `CRC_BYTES;
                            crc_cnt_ff <= crc_cnt_ff + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Two-step capture; set beats a same-cycle clear
    logic cap_set, cap_clr;
    assign cap_set = in_fire && state_ff == TX_DATA && first_ff
        && two_step_capture_flag && tx_active;
    assign cap_clr = do_write && awaddr_ff == `ADDR_STATUS && wstrb_ff[0]
        && wdata_ff[`ST_CAP_VALID_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_ff <= '0;
            cap_valid_ff <= 1'b0;
        end else if (cap_set) begin
            cap_ff <= sys_time;
            cap_valid_ff <= 1'b1;
        end else if (cap_clr) begin
            cap_valid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Receive stamp posting; a stamp arriving while one is pending is dropped
    stamp_t rx_stamp_ff;
    logic rx_have_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_stamp_ff <= '0;
            rx_have_ff <= 1'b0;
            rx_post_time <= '0;
            rx_post_valid <= 1'b0;
        end else begin
            if (rx_in_valid && rx_in_first) begin
                rx_stamp_ff <= sys_time;
                rx_have_ff <= active;
            end else if (rx_in_valid && rx_in_last) begin
                rx_have_ff <= 1'b0;
            end
            if (rx_post_valid && rx_post_ready) begin
                rx_post_valid <= 1'b0;
            end else if (rx_in_valid && rx_in_last && rx_in_event && rx_have_ff
                    && !rx_in_first && !rx_post_valid) begin
                rx_post_time <= rx_stamp_ff;
                rx_post_valid <= 1'b1;
            end
        end
    end
endmodule : ptp_ts_unit
`default_nettype wire

// ===== testbench/phy_sink.sv
// Purpose: PHY byte sink and host post acceptor
// Assumes: one clock with the unit
// Notes: acceptance follows a free LFSR, stalls of up to a few cycles
`timescale 1ns/1ns
`default_nettype none
module phy_sink (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tx_out_ready,
    output logic rx_post_ready
);
    logic [7:0] lfsr_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) lfsr_ff <= 8'h5A;
        else lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end
    // Uneven so both prompt and slow acceptance occur
    assign tx_out_ready = lfsr_ff[0] | lfsr_ff[1];
    assign rx_post_ready = lfsr_ff[3];
endmodule : phy_sink
`default_nettype wire

// ===== testbench/ptp_ts_unit_props.sv
// Purpose: port-level checks of the timestamp unit
// Assumes: bound to every ptp_ts_unit instance
// Notes: bus handshake checks carry no tag
`timescale 1ns/1ns
`default_nettype none
module ptp_ts_unit_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic tx_in_valid,
    input wire logic tx_in_ready,
    input wire logic tx_in_last,
    input wire logic tx_out_valid,
    input wire logic tx_out_ready,
    input wire logic [7:0] tx_out_data,
    input wire logic rx_in_valid,
    input wire logic rx_in_last,
    input wire logic rx_in_event,
    input wire logic rx_post_valid,
    input wire logic rx_post_ready,
    input wire logic [79:0] rx_post_time
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_bus_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    a_tx_answer: assert property (tx_in_valid && tx_in_ready |=> tx_out_valid)
        else $error("tx byte latency wrong");
    a_txout_holds: assert property (tx_out_valid && !tx_out_ready |=> $stable(tx_out_data))
        else $error("tx byte moved while stalled");
    a_crc_gap: assert property (tx_in_valid && tx_in_ready && tx_in_last |=>
        !tx_in_ready [*4]) else $error("input taken during crc");
    a_post_cause: assert property ($rose(rx_post_valid) |->
        $past(rx_in_valid && rx_in_last && rx_in_event)) else $error("post without event");
    a_post_holds: assert property (rx_post_valid && !rx_post_ready |=>
        rx_post_valid && $stable(rx_post_time)) else $error("post moved early");
endmodule : ptp_ts_unit_props
bind ptp_ts_unit ptp_ts_unit_props u_ptp_ts_unit_props (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: self-checking bench of the timestamp unit
// Assumes: phy_sink stands at the PHY and host sides
// Notes: tx bytes and rx posts are checked through queues
`timescale 1ns/1ns
`default_nettype none
`include "ptp_ts_cfg.svh"
module testbench
    import ptp_ts_pkg::*;
();
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, tx_in_valid = 0, tx_in_last = 0;
    logic two_step_capture_flag = 0, one_step_insert_flag = 0, full_duplex = 1;
    logic rx_in_valid = 0, rx_in_first = 0, rx_in_last = 0, rx_in_event = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tx_in_data = 0, tx_out_data;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready, rx_post_valid, rx_post_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    stamp_t sys_time = 0, rx_post_time, cap = 0;
    logic [8:0] txq[$];
    stamp_t rxq[$];
    int n_fail = 0, checks = 0, cyc = 0;
    logic dis = 0, en = 0;
    logic [15:0] off = 0;
    always #10 aclk = ~aclk;
    ptp_ts_unit u_ptp_ts_unit (.*);
    phy_sink u_phy_sink (.*);
    // ==========================================================
    // Reporting
    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk
    // About thirty times the expected run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    always @(posedge aclk) if (aresetn && tx_out_valid && tx_out_ready) begin
        if (txq.size() == 0) chk(1, 0, "extra tx byte");
        else chk({tx_out_last, tx_out_data}, txq.pop_front(), "tx byte");
    end
    always @(posedge aclk) if (aresetn && rx_post_valid && rx_post_ready) begin
        if (rxq.size() == 0) chk(1, 0, "extra post");
        else chk(rx_post_time, rxq.pop_front(), "rx post");
    end
    // ==========================================================
    // Drivers
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er, "bresp");
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk({s_axi_rresp, s_axi_rdata}, {er, e}, "read");
    endtask : rd
    function automatic logic [31:0] crc(input logic [7:0] b[$]);
        logic [31:0] c;
        c = `CRC_INIT;
        foreach (b[i]) begin
            c = c ^ b[i];
            repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc
    task automatic frame(input int n, input logic one, input logic two);
        logic [7:0] b[$], e[$];
        logic [31:0] c;
        stamp_t st;
        st = {16'($urandom), $urandom, $urandom};
        for (int i = 0; i < n; i++) b.push_back(8'($urandom));
        if (one) for (int k = 0; k < 10; k++) b[off + k] = 0;
        // Zeros go in; only the expected copy carries the stamp
        e = b;
        if (full_duplex && !dis && en && one)
            for (int k = 0; k < 10; k++) e[off + k] = st[79 - 8 * k -: 8];
        for (int i = 0; i < n; i++) txq.push_back({1'b0, e[i]});
        if (full_duplex && !dis && en && two) cap = st;
        c = crc(e);
        for (int k = 0; k < 4; k++) txq.push_back({k == 3, c[8 * k +: 8]});
        @(posedge aclk);
        sys_time <= st;
        for (int i = 0; i < n; i++) begin
            tx_in_data <= b[i];
            tx_in_valid <= 1;
            tx_in_last <= i == n - 1;
            one_step_insert_flag <= one;
            two_step_capture_flag <= two;
            do @(posedge aclk); while (tx_in_ready !== 1'b1);
        end
        tx_in_valid <= 0;
        tx_in_last <= 0;
        repeat (12) @(posedge aclk);
    endtask : frame
    task automatic rxf(input int n, input logic ev);
        stamp_t st;
        st = {16'($urandom), $urandom, $urandom};
        if (ev && n > 1 && full_duplex && !dis) rxq.push_back(st);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            if (i == 0) sys_time <= st;
            rx_in_valid <= 1;
            rx_in_first <= i == 0;
            rx_in_last <= i == n - 1;
            rx_in_event <= ev;
        end
        @(posedge aclk);
        rx_in_valid <= 0;
        repeat (20) @(posedge aclk);
    endtask : rxf
    task automatic rd_cap();
        rd(`ADDR_CAP_NS, cap[31:0], `AXI_OKAY);
        rd(`ADDR_CAP_SEC_LO, cap[63:32], `AXI_OKAY);
        rd(`ADDR_CAP_SEC_HI, {16'h0000, cap[79:64]}, `AXI_OKAY);
    endtask : rd_cap
    // ==========================================================
    // Tests
    initial begin
        void'($urandom(32'h7128));
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        rd(`ADDR_AUX_CTRL, 32'h0, `AXI_OKAY);
        rd(`ADDR_TX_CTRL, 32'h0, `AXI_OKAY);
        rd_cap();
        rd(8'h40, 32'h0, `AXI_SLVERR);
        wr(8'h40, 32'hFFFFFFFF, `AXI_SLVERR);
        rd(`ADDR_STATUS, 32'h6, `AXI_OKAY);
        $display("test registers done");
        en = 1;
        for (int k = 0; k < 2; k++) begin
            off = 16'(k * 6);
            wr(`ADDR_TX_CTRL, {off, 16'h0001}, `AXI_OKAY);
            frame(16, 1, 0);
        end
        frame(12, 0, 1);
        rd_cap();
        rd(`ADDR_STATUS, 32'h7, `AXI_OKAY);
        wr(`ADDR_STATUS, 32'h1, `AXI_OKAY);
        frame(10, 0, 0);
        rd_cap();
        rd(`ADDR_STATUS, 32'h6, `AXI_OKAY);
        $display("test transmit done");
        rxf(5, 1);
        rxf(4, 0);
        rxf(1, 1);
        rxf(2, 1);
        $display("test receive done");
        full_duplex <= 0;
        repeat (4) @(posedge aclk);
        frame(16, 1, 1);
        rxf(4, 1);
        rd(`ADDR_STATUS, 32'h0, `AXI_OKAY);
        full_duplex <= 1;
        dis = 1;
        wr(`ADDR_AUX_CTRL, 32'h1, `AXI_OKAY);
        frame(16, 1, 1);
        rxf(4, 1);
        rd_cap();
        rd(`ADDR_STATUS, 32'h2, `AXI_OKAY);
        $display("test inactive done");
        repeat (60) @(posedge aclk);
        chk(txq.size() + rxq.size(), 0, "results missing");
        summarize();
    end
endmodule : testbench
`default_nettype wire
